/* File: verilog/popl_pkg.sv */
// constants shared by the permissive over-reach pilot logic
package popl_pkg;

  // ----------------------------------------------------------------
  // clocking and evaluation tick
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES    = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int APB_AW   = 8;
  localparam int APB_DW   = 32;
  localparam int SET_W    = 16;
  localparam int SET_N    = 7;
  localparam int IN_N     = 4;
  localparam int STATUS_W = 11;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [APB_AW-1:0] OFF_CTRL     = 8'h00;
  localparam logic [APB_AW-1:0] OFF_SET_BASE = 8'h04;
  localparam logic [APB_AW-1:0] OFF_SET_LAST = 8'h1C;
  localparam logic [APB_AW-1:0] OFF_STATUS   = 8'h20;

  // setting slots, one word each from OFF_SET_BASE upward
  localparam int SET_RX_QUAL  = 0;
  localparam int SET_GND_WIN  = 1;
  localparam int SET_GND_HOLD = 2;
  localparam int SET_ECHO_DUR = 3;
  localparam int SET_ECHO_LCK = 4;
  localparam int SET_OPEN_DLY = 5;
  localparam int SET_STRETCH  = 6;

  // control field positions and reset values
  localparam int CTRL_ECHO_BIT = 0;
  localparam int CTRL_GND_BIT  = 1;
  localparam int CTRL_W        = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
  localparam logic [SET_W-1:0]  SET_RESET  = 16'h0000;

  // synchronised input positions
  localparam int IN_RX   = 0;
  localparam int IN_ZONE = 1;
  localparam int IN_GND  = 2;
  localparam int IN_OPEN = 3;

  // echo sequencer, one-hot
  typedef enum logic [2:0] {
    ECHO_IDLE = 3'b001,
    ECHO_SEND = 3'b010,
    ECHO_LOCK = 3'b100
  } popl_echo_type;

endpackage : popl_pkg

/* File: verilog/popl_pickup.sv */
// continuous-presence pickup timer counted in evaluation ticks
module popl_pickup #(
  parameter int TW = popl_pkg::SET_W
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          ce,
  input  wire logic          tick,
  input  wire logic          level,
  input  wire logic [TW-1:0] delay,
  output logic               qualified
);
  import popl_pkg::*;

  typedef struct packed {
    logic [TW-1:0] cnt;
    logic          q;
  } popl_pk_state_type;

  popl_pk_state_type s_r;
  popl_pk_state_type s_nxt;

  if (TW < 1 || TW > APB_DW) begin : g_bad_width
    $error("popl_pickup: TW out of range");
  end

  always_comb begin
    s_nxt = s_r;
    if (!level) begin
      // any dropout restarts the qualification
      s_nxt.cnt = '0;
      s_nxt.q   = 1'b0;
    end else if (delay == '0) begin
      s_nxt.q = 1'b1;
    end else if (tick && !s_r.q) begin
      if (s_r.cnt + TW'(1) >= delay) begin
        s_nxt.q = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + TW'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign qualified = s_r.q;

endmodule : popl_pickup

/* File: verilog/popl_top.sv */
// permissive over-reach pilot logic with APB settings access
//
// How it works
// - trip only when the local over-reaching zone or the selected ground forward input sees the fault and a qualified remote receive agrees.
// - transmit is keyed while the zone pickup or the selected ground forward input is active.
// - the receive input counts only after staying high for the receive qualify delay.
// - the ground path uses the qualified receive only while the ground window is still open.
// - ground receive is delayed, cut at the window time after raw pickup, then held off.
// - the window and holdoff affect only the ground path, never the zone path.
// - with echo enabled, a qualified receive under validated open line end sends an echo.
// - the echo is a one-shot followed by an echo lockout period.
// - the echo pulse ends on the tick that completes the echo duration count, so up to one tick short, whatever the receive looks like.
// - open line end is valid only after persisting for its pickup delay.
// - every trip pulse is stretched to the trip stretch time counted in ticks from its rise, so up to one tick short.
//
// The APB register port and the address map were decided locally.
module popl_top #(
  parameter int TICK_DIV = popl_pkg::TICK_CYCLES,
  parameter int TW       = popl_pkg::SET_W
) (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic                         ce,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [popl_pkg::APB_AW-1:0]  paddr,
  input  wire logic [popl_pkg::APB_DW-1:0]  pwdata,
  output logic      [popl_pkg::APB_DW-1:0]  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         permissive_receive_in,
  input  wire logic                         zone_forward_in,
  input  wire logic                         ground_forward_in,
  input  wire logic                         open_end_detect_in,
  output logic                              permissive_transmit_out,
  output logic                              scheme_trip_out,
  output logic                              echo_send_out
);
  import popl_pkg::*;

  localparam int TICK_W = 16;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_tick
    $error("popl_top: TICK_DIV out of range");
  end
  if (TW < 1 || TW > APB_DW) begin : g_bad_width
    $error("popl_top: TW out of range");
  end

  // settings arrive through the low data bits only
  if (TW > SET_W) begin : g_bad_set_width
    $error("popl_top: TW wider than a setting word");
  end

  // the synchroniser vector is packed by position, four pins only
  if (IN_N != 4) begin : g_bad_in_count
    $error("popl_top: input count must be four");
  end
  if (IN_RX >= IN_N || IN_ZONE >= IN_N
      || IN_GND >= IN_N || IN_OPEN >= IN_N) begin : g_bad_in_pos
    $error("popl_top: input position outside the vector");
  end

  // status word: synced pins plus seven scheme flags
  if (STATUS_W != IN_N + 7) begin : g_bad_status_width
    $error("popl_top: status width does not match its fields");
  end
  if (STATUS_W > APB_DW) begin : g_bad_status_fit
    $error("popl_top: status wider than the data bus");
  end

  // control bits must sit inside the control field
  if (CTRL_W > APB_DW) begin : g_bad_ctrl_width
    $error("popl_top: control field wider than the data bus");
  end
  if (CTRL_ECHO_BIT >= CTRL_W || CTRL_GND_BIT >= CTRL_W) begin : g_bad_ctrl
    $error("popl_top: control bit outside the control field");
  end

  // slot index is three address bits, so at most eight slots
  if (SET_N < 1 || SET_N > 8) begin : g_bad_slot_count
    $error("popl_top: setting slot count out of range");
  end
  if (SET_RX_QUAL >= SET_N || SET_GND_WIN >= SET_N
      || SET_GND_HOLD >= SET_N || SET_ECHO_DUR >= SET_N
      || SET_ECHO_LCK >= SET_N || SET_OPEN_DLY >= SET_N
      || SET_STRETCH >= SET_N) begin : g_bad_slot_pos
    $error("popl_top: setting slot outside the slot array");
  end

  // the decoder assumes one word per slot, packed without holes
  if (int'(OFF_SET_LAST) - int'(OFF_SET_BASE)
      != 4 * (SET_N - 1)) begin : g_bad_map
    $error("popl_top: setting window does not match slot count");
  end
  if (OFF_STATUS <= OFF_SET_LAST || OFF_CTRL >= OFF_SET_BASE)
    begin : g_bad_order
    $error("popl_top: register map overlaps");
  end
  if (OFF_SET_BASE[1:0] != 2'h0 || OFF_STATUS[1:0] != 2'h0)
    begin : g_bad_align
    $error("popl_top: register offset not word aligned");
  end

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [IN_N-1:0]            in_s1;
    logic [IN_N-1:0]            in_s2;
    logic [TICK_W-1:0]          tick_cnt;
    logic                       tick;
    logic [CTRL_W-1:0]          ctrl;
    logic [SET_N-1:0][TW-1:0]   set;
    logic [TW-1:0]              win_cnt;
    logic                       gnd_blocked;
    logic [TW-1:0]              hold_cnt;
    logic                       raw_prev;
    logic [TW-1:0]              stretch_cnt;
    logic                       rxq_prev;
    popl_echo_type              echo_st;
    logic [TW-1:0]              echo_cnt;
    logic                       trip;
    logic                       tx;
    logic                       echo;
    logic                       pready;
    logic                       pslverr;
    logic [APB_DW-1:0]          prdata;
  } popl_state_type;

  popl_state_type s_r;
  popl_state_type s_nxt;

  // ----------------------------------------------------------------
  // qualification timers for receive and open line end
  // ----------------------------------------------------------------
  logic [1:0]         pk_in;
  logic [1:0][TW-1:0] pk_dly;
  logic [1:0]         pk_out;

  assign pk_in[0]  = s_r.in_s2[IN_RX];
  assign pk_dly[0] = s_r.set[SET_RX_QUAL];
  assign pk_in[1]  = s_r.in_s2[IN_OPEN];
  assign pk_dly[1] = s_r.set[SET_OPEN_DLY];

  for (genvar g = 0; g < 2; g++) begin : g_pickup
    popl_pickup #(
      .TW (TW)
    ) u_pickup (
      .clk       (clk),
      .reset     (reset),
      .ce        (ce),
      .tick      (s_r.tick),
      .level     (pk_in[g]),
      .delay     (pk_dly[g]),
      .qualified (pk_out[g])
    );
  end

  logic rx_q;
  logic open_valid;
  assign rx_q       = pk_out[0];
  assign open_valid = pk_out[1];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic                    rx_raw;
  logic                    zone;
  logic                    gnd;
  logic                    gnd_sel;
  logic                    gnd_rx;
  logic                    trip_raw;
  logic                    setup;
  logic                    access;
  logic                    in_set;
  logic [APB_AW-1:0]       set_off;
  logic [2:0]              set_idx;
  logic [STATUS_W-1:0]     status;

  always_comb begin
    s_nxt = s_r;

    // two-stage input synchroniser
    s_nxt.in_s1 = {open_end_detect_in, ground_forward_in,
                   zone_forward_in, permissive_receive_in};
    s_nxt.in_s2 = s_r.in_s1;

    rx_raw  = s_r.in_s2[IN_RX];
    zone    = s_r.in_s2[IN_ZONE];
    gnd     = s_r.in_s2[IN_GND];
    gnd_sel = gnd & s_r.ctrl[CTRL_GND_BIT];

    // evaluation tick
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt == TICK_LAST) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick     = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + TICK_W'(1);
    end

    // ground window: timed from the raw receive pickup
    if (!s_r.gnd_blocked) begin
      if (!rx_raw) begin
        s_nxt.win_cnt = '0;
      end else if (s_r.tick && s_r.set[SET_GND_WIN] != '0) begin
        if (s_r.win_cnt + TW'(1) >= s_r.set[SET_GND_WIN]) begin
          s_nxt.gnd_blocked = 1'b1;
          s_nxt.hold_cnt    = s_r.set[SET_GND_HOLD];
        end else begin
          s_nxt.win_cnt = s_r.win_cnt + TW'(1);
        end
      end
    end else if (s_r.hold_cnt != '0) begin
      if (s_r.tick) begin
        s_nxt.hold_cnt = s_r.hold_cnt - TW'(1);
      end
    end else if (!rx_raw) begin
      // holdoff done and receive gone: rearm the window
      s_nxt.gnd_blocked = 1'b0;
      s_nxt.win_cnt     = '0;
    end

    // blocking touches the ground path only
    gnd_rx   = rx_q & ~s_r.gnd_blocked & s_r.ctrl[CTRL_GND_BIT];
    trip_raw = (zone & rx_q) | (gnd & gnd_rx);

    // trip stretch
    s_nxt.raw_prev = trip_raw;
    if (trip_raw && !s_r.raw_prev) begin
      s_nxt.stretch_cnt = s_r.set[SET_STRETCH];
    end else if (s_r.tick && s_r.stretch_cnt != '0) begin
      s_nxt.stretch_cnt = s_r.stretch_cnt - TW'(1);
    end
    s_nxt.trip = trip_raw | (s_r.stretch_cnt != '0);

    // echo one-shot and lockout
    s_nxt.rxq_prev = rx_q;
    case (s_r.echo_st)
      ECHO_IDLE: begin
        if (s_r.ctrl[CTRL_ECHO_BIT] && rx_q && !s_r.rxq_prev
            && open_valid && s_r.set[SET_ECHO_DUR] != '0) begin
          s_nxt.echo_st  = ECHO_SEND;
          s_nxt.echo_cnt = s_r.set[SET_ECHO_DUR];
        end
      end
      ECHO_SEND: begin
        if (s_r.tick) begin
          if (s_r.echo_cnt == TW'(1)) begin
            s_nxt.echo_cnt = s_r.set[SET_ECHO_LCK];
            s_nxt.echo_st  = (s_r.set[SET_ECHO_LCK] != '0) ? ECHO_LOCK
                                                            : ECHO_IDLE;
          end else begin
            s_nxt.echo_cnt = s_r.echo_cnt - TW'(1);
          end
        end
      end
      ECHO_LOCK: begin
        if (s_r.tick) begin
          if (s_r.echo_cnt == TW'(1)) begin
            s_nxt.echo_cnt = '0;
            s_nxt.echo_st  = ECHO_IDLE;
          end else begin
            s_nxt.echo_cnt = s_r.echo_cnt - TW'(1);
          end
        end
      end
      default: begin
        s_nxt.echo_st  = ECHO_IDLE;
        s_nxt.echo_cnt = '0;
      end
    endcase
    s_nxt.echo = (s_nxt.echo_st == ECHO_SEND);

    // echo rides on the transmit key as well
    s_nxt.tx = zone | gnd_sel | s_nxt.echo;

    // ----------------------------------------------------------------
    // APB slave: one wait-free access, answer prepared in setup
    // ----------------------------------------------------------------
    setup   = psel & ~penable;
    access  = psel & penable & s_r.pready;
    set_off = paddr - OFF_SET_BASE;
    set_idx = set_off[4:2];
    in_set  = (paddr >= OFF_SET_BASE) && (paddr <= OFF_SET_LAST)
              && (paddr[1:0] == 2'h0);
    status  = {s_r.tx, s_r.trip, (s_r.echo_st == ECHO_LOCK),
               (s_r.echo_st == ECHO_SEND), s_r.gnd_blocked,
               open_valid, rx_q, s_r.in_s2};

    s_nxt.pready  = setup;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata  = '0;
    if (setup) begin
      if (paddr == OFF_CTRL) begin
        s_nxt.prdata = APB_DW'(s_r.ctrl);
      end else if (paddr == OFF_STATUS) begin
        s_nxt.prdata = APB_DW'(status);
      end else if (in_set) begin
        s_nxt.prdata = APB_DW'(s_r.set[set_idx]);
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end

    // status is read-only; refused writes leave state alone
    if (access && pwrite && !s_r.pslverr) begin
      if (paddr == OFF_CTRL) begin
        s_nxt.ctrl = pwdata[CTRL_W-1:0];
      end else if (in_set) begin
        s_nxt.set[set_idx] = pwdata[TW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r          <= '0;
      s_r.ctrl     <= CTRL_RESET;
      s_r.set      <= {SET_N{TW'(SET_RESET)}};
      s_r.echo_st  <= ECHO_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  assign prdata                  = s_r.prdata;
  assign pready                  = s_r.pready;
  assign pslverr                 = s_r.pslverr;
  assign permissive_transmit_out = s_r.tx;
  assign scheme_trip_out         = s_r.trip;
  assign echo_send_out           = s_r.echo;

endmodule : popl_top

/* File: dv/popl_checker.sv */
// port assertions for the pilot logic
module popl_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic permissive_receive_in,
  input wire logic zone_forward_in,
  input wire logic ground_forward_in,
  input wire logic open_end_detect_in,
  input wire logic permissive_transmit_out,
  input wire logic scheme_trip_out,
  input wire logic echo_send_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // recent input history, slice k holds inputs k+1 cycles back
  // ----------------------------------------------------------------
  logic [17:0] h_r;
  logic        rx_rc, loc_rc, op_rc;
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      h_r <= '0;
    else
      h_r <= {h_r[14:0], permissive_receive_in,
              zone_forward_in | ground_forward_in, open_end_detect_in};
  end
  // wide windows: sync and timer alignment shift causes by a cycle or two
  assign rx_rc  = h_r[5] | h_r[8] | h_r[11] | h_r[14] | h_r[17];
  assign loc_rc = h_r[4] | h_r[7] | h_r[10] | h_r[13] | h_r[16];
  assign op_rc  = h_r[3] | h_r[6] | h_r[9] | h_r[12];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_tx_key;
    (ce && zone_forward_in)[*3] |=> permissive_transmit_out;
  endproperty
  a_tx_key: assert property (p_tx_key)
    else $error("transmit not keyed by zone");
  property p_tx_idle;
    (!zone_forward_in && !ground_forward_in && !echo_send_out)[*4]
      |-> !permissive_transmit_out;
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("transmit keyed without cause");
  property p_trip_rx;
    $rose(scheme_trip_out) |-> rx_rc;
  endproperty
  a_trip_rx: assert property (p_trip_rx)
    else $error("trip without remote receive");
  property p_trip_loc;
    $rose(scheme_trip_out) |-> loc_rc;
  endproperty
  a_trip_loc: assert property (p_trip_loc)
    else $error("trip without local forward pickup");
  property p_echo_rx;
    $rose(echo_send_out) |-> rx_rc;
  endproperty
  a_echo_rx: assert property (p_echo_rx)
    else $error("echo without receive");
  property p_echo_open;
    $rose(echo_send_out) |-> op_rc;
  endproperty
  a_echo_open: assert property (p_echo_open)
    else $error("echo without open line end");
  property p_echo_tx;
    echo_send_out && $past(echo_send_out) |-> permissive_transmit_out;
  endproperty
  a_echo_tx: assert property (p_echo_tx)
    else $error("echo not on transmit");
  property p_apb_ack;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_ack: assert property (p_apb_ack)
    else $error("access cycle not one wait-free cycle");
  c_trip: cover property ($rose(scheme_trip_out));
  c_echo: cover property ($rose(echo_send_out));
  c_err: cover property (pready && pslverr);
endmodule : popl_checker

bind popl_top popl_checker chk (.clk, .reset, .ce, .psel, .penable,
  .pready, .pslverr, .permissive_receive_in, .zone_forward_in,
  .ground_forward_in, .open_end_detect_in, .permissive_transmit_out,
  .scheme_trip_out, .echo_send_out);

/* File: dv/popl_remote.sv */
// far-end relay: keys permissive while it sees the fault ahead
module popl_remote (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       fault_fwd,
  input  wire logic [7:0] burst,
  output logic            rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_r;
  // nonzero burst loads a spurious key of that many clocks
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      left_r <= 8'h00;
    else if (burst != 8'h00)
      left_r <= burst;
    else if (left_r != 8'h00)
      left_r <= left_r - 8'h01;
  end
  assign rx = fault_fwd | (left_r != 8'h00);
endmodule : popl_remote

/* File: dv/testbench.sv */
// self-checking bench for the pilot logic
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  failures++; $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import popl_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, ce = 1'b1, eq = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, burst = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, se, rx, tx, trip, echo;
  logic        zone = 1'b0, gnd = 1'b0, opn = 1'b0, ffwd = 1'b0;
  int          failures = 0, n_tests = 0, trip_n = 0, echo_n = 0;
  int          echo_up = 0, t0, t1, n;
  always #10 clk = ~clk;
  // ----------------------------------------------------------------
  // pulse counters, sampled mid-cycle away from the driving edge
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (trip === 1'b1) trip_n++;
    if (echo === 1'b1) echo_n++;
    if (echo === 1'b1 && eq !== 1'b1) echo_up++;
    eq = echo;
  end
  popl_top #(.TICK_DIV(4)) dut (.clk, .reset, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .permissive_receive_in(rx), .zone_forward_in(zone),
    .ground_forward_in(gnd), .open_end_detect_in(opn),
    .permissive_transmit_out(tx), .scheme_trip_out(trip),
    .echo_send_out(echo));
  popl_remote far (.clk, .reset, .fault_fwd(ffwd), .burst, .rx);
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) failures++;
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, q)
    `CHK("pslverr", ee, se)
  endtask : rd
  task automatic set(input int s, input int v);
    apb(1'b1, OFF_SET_BASE + 8'(4 * s), 32'(v));
  endtask : set
  // one-clock load request to the far end
  task automatic key(input int c);
    burst <= 8'(c);
    @(posedge clk);
    burst <= 8'h00;
  endtask : key
  task automatic wtrip(input int m);
    n = 0;
    while (trip !== 1'b1 && n < m) begin
      @(posedge clk);
      n++;
    end
  endtask : wtrip
  task automatic end_sim();
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  initial begin
    cyc(5000);
    failures++;
    end_sim();
  end
  initial begin
    cyc(20);
    reset <= 1'b0;
    rd(OFF_CTRL, 32'h0, 1'b0);
    rd(OFF_SET_LAST, 32'h0, 1'b0);
    rd(8'h24, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    apb(1'b1, OFF_SET_BASE, 32'hFFFFA5C3);
    rd(OFF_SET_BASE, 32'h0000A5C3, 1'b0);
    set(SET_RX_QUAL, 3);
    set(SET_STRETCH, 5);
    zone <= 1'b1;
    cyc(6);
    `CHK("tx_zone", 1'b1, tx)
    key(6);
    cyc(30);
    `CHK("trip_spur", 1'b0, trip)
    ffwd <= 1'b1;
    wtrip(40);
    `CHK("qual_wait", 1'b1, n >= 8 && n < 40)
    t0 = trip_n;
    zone <= 1'b0;
    ffwd <= 1'b0;
    cyc(40);
    n = trip_n - t0;
    `CHK("stretch", 1'b1, n >= 15 && n <= 26)
    set(SET_RX_QUAL, 0);
    set(SET_STRETCH, 0);
    set(SET_GND_WIN, 4);
    set(SET_GND_HOLD, 20);
    apb(1'b1, OFF_CTRL, 32'h2);
    gnd <= 1'b1;
    cyc(6);
    `CHK("tx_gnd", 1'b1, tx)
    `CHK("trip_local", 1'b0, trip)
    ffwd <= 1'b1;
    wtrip(10);
    `CHK("gnd_trip", 1'b1, trip)
    cyc(28);
    `CHK("gnd_cut", 1'b0, trip)
    zone <= 1'b1;
    cyc(6);
    `CHK("zone_trip", 1'b1, trip)
    zone <= 1'b0;
    ffwd <= 1'b0;
    cyc(3);
    ffwd <= 1'b1;
    cyc(10);
    `CHK("gnd_hold", 1'b0, trip)
    ffwd <= 1'b0;
    cyc(100);
    ffwd <= 1'b1;
    wtrip(10);
    `CHK("gnd_free", 1'b1, trip)
    ffwd <= 1'b0;
    gnd <= 1'b0;
    set(SET_OPEN_DLY, 3);
    set(SET_ECHO_DUR, 3);
    set(SET_ECHO_LCK, 10);
    apb(1'b1, OFF_CTRL, 32'h1);
    t1 = echo_up;
    opn <= 1'b1;
    key(20);
    cyc(30);
    `CHK("echo_early", t1, echo_up)
    t0 = echo_n;
    key(2);
    cyc(24);
    `CHK("echo_sent", t1 + 1, echo_up)
    n = echo_n - t0;
    `CHK("echo_len", 1'b1, n >= 8 && n <= 12)
    key(2);
    cyc(24);
    `CHK("echo_lock", t1 + 1, echo_up)
    cyc(20);
    key(2);
    cyc(24);
    `CHK("echo_again", t1 + 2, echo_up)
    cyc(60);
    apb(1'b1, OFF_CTRL, 32'h0);
    key(2);
    cyc(24);
    `CHK("echo_off", t1 + 2, echo_up)
    opn <= 1'b0;
    zone <= 1'b1;
    ffwd <= 1'b1;
    wtrip(20);
    `CHK("trip_pre_rst", 1'b1, trip)
    reset <= 1'b1;
    zone <= 1'b0;
    ffwd <= 1'b0;
    cyc(2);
    `CHK("trip_rst", 1'b0, trip)
    `CHK("tx_rst", 1'b0, tx)
    reset <= 1'b0;
    rd(OFF_SET_BASE + 8'h10, 32'h0, 1'b0);
    rd(OFF_CTRL, 32'h0, 1'b0);
    end_sim();
  end
endmodule : testbench
